// file: design/asir_regs.v
// Purpose: active control and range image registers
// Assumes: register port is the device's internal slave port
// Notes: images load from pending registers on cycle end
`timescale 1ns/1ps
`include "asir_defines.vh"
module asir_regs #(
  parameter CTRL_RESET = `ASIR_CTRL_RESET,
  parameter VALID_NS = `ASIR_VALID_NS,
  parameter VALID_CYC = VALID_NS / `ASIR_CLK_NS
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register access port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_auto_inc,
  input wire skip_override,
  output reg [15:0] reg_rdata,
  output reg [7:0] next_addr,
  // refresh and conversion events
  input wire refresh,
  input wire cycle_done,
  // multipurpose pins
  input wire pin1_in,
  input wire pin2_in,
  output wire pin1_out,
  output wire pin1_oe_n,
  output wire pin2_out,
  output wire pin2_oe_n,
  // active state to converter
  output wire [3:0] chan_active,
  output wire [3:0] rate_code,
  output wire [1:0] rate_sel,
  output wire sleep,
  output wire single_shot,
  output wire fast,
  output wire burst,
  output wire [15:0] range_active,
  output wire images_valid
);
  // overview
  // host writes land only in the pending and gp data registers; the active
  // images never take a host write, so reads of them always show
  // what the converter is really using
  //
  // commit flow
  // - a refresh of any variant arms one commit
  // - the commit waits for the end of the running conversion cycle
  // - at that edge both images load whole from their pending words
  // - the converter keeps its old rate right up to that edge
  // - so an image may lag its refresh by up to one whole cycle,
  //   and the lag depends on where in the cycle the refresh fell
  // - a refresh in the very edge of a cycle end arms the next end;
  //   the end that is passing has already been claimed
  // - pending words are taken at commit time, not refresh time;
  //   a write between refresh and cycle end still makes it in
  //
  // validity
  // - a timer restarts on every refresh variant
  // - the flag rises a fixed count of clocks later
  // - after reset the flag rises once the timer first runs out
  // - the count comes from a time and the clock period; a bench
  //   may shorten it through the cycle parameter
  //
  // control image layout
  // - sampling mode code in the top nibble
  // - pin two role, then pin one role, two bits each
  // - channel disable mask in the next nibble
  // - low nibble has no storage and always reads zero
  //
  // multipurpose pins
  // - pin levels arrive unsynchronised and pass two flops first
  // - gp input role: data register shows the pin level
  // - gp output role: pin driven from the data register
  // - low-rate role: a high pin forces the slowest rate in adaptive and continuous modes
  // - alert role: no alert source lives here; the pin stays
  //   undriven from this block
  //
  // register pointer
  // - each access leaves the following address in next_addr
  // - with auto-increment on, an address of a disabled channel
  //   is stepped over, unless the override level is high
  // - only one disabled channel is stepped over per access; two
  //   disabled neighbours need the caller to skip again
  //
  // limitations
  // - unmapped reads return zero rather than an error
  // - the range image reset is one fixed word for every variant
  // - the control reset is a parameter, one value per variant
  reg [15:0] ctrl_pend_q; // pending control setting
  reg [15:0] range_pend_q; // pending range setting
  reg [15:0] active_control_image_q; // active control image
  reg [15:0] range_act_q; // active range image
  reg [1:0] gpio_out_q; // written gp output values
  reg commit_q; // refresh seen, waiting for cycle end
  reg [31:0] valid_cnt_q; // clocks since last refresh, held once valid
  reg valid_q; // images and results readable
  wire [1:0] pin_sync; // synchronised pin levels, bit 0 pin one
  wire [1:0] pin1_fn; // role of pin one from the active image
  wire [1:0] pin2_fn; // role of pin two from the active image
  wire [3:0] pin_fn; // both roles, pin one in the low pair
  wire [1:0] pin_slow; // per pin: low-rate role and pin high
  wire [1:0] pin_drive; // per pin: gp output role
  wire [1:0] pin_rd; // per pin: bit shown in the gp data word
  wire slow_force; // any pin asks for the slowest rate
  wire [15:0] ctrl_commit; // pending image with dead bits cleared
  // write strobes, one per writable register
  wire wr_ctrl_pend; // pending control written
  wire wr_range_pend; // pending range written
  wire wr_gpio; // gp output values written
  // pointer helpers
  wire [7:0] step_addr; // plain following address
  wire [7:0] chan_off; // offset of that address in channel block
  wire skip_zone; // following address lies in the channel block
  // pins arrive from outside the clock domain
  asir_sync2 #(.W(2)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({pin2_in, pin1_in}),
    .sync_out(pin_sync)
  );
  assign pin1_fn = active_control_image_q[`ASIR_PIN1_MSB:`ASIR_PIN1_LSB];
  assign pin2_fn = active_control_image_q[`ASIR_PIN2_MSB:`ASIR_PIN2_LSB];
  assign pin_fn = {pin2_fn, pin1_fn};
  // per-pin role decode; both pins share one encoding
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      // low-rate role only counts while the pin is high
      assign pin_slow[gi] =
        (pin_fn[2*gi+1:2*gi] == `ASIR_PIN_SLOW) &&
        pin_sync[gi];
      // output role is the only one that drives the pin
      assign pin_drive[gi] =
        (pin_fn[2*gi+1:2*gi] == `ASIR_PIN_GPOUT);
      // input role shows the pin, other roles the written value
      assign pin_rd[gi] =
        (pin_fn[2*gi+1:2*gi] == `ASIR_PIN_GPIN) ?
        pin_sync[gi] : gpio_out_q[gi];
    end
  endgenerate
  // either pin in low-rate role and high forces slow rate in adaptive and continuous modes
  assign slow_force = |pin_slow;
  // outputs always carry the register; oe is active low
  assign pin1_out = gpio_out_q[0];
  assign pin2_out = gpio_out_q[1];
  assign pin1_oe_n = ~pin_drive[0];
  assign pin2_oe_n = ~pin_drive[1];
  // write decode; the active images have no write strobe at all
  assign wr_ctrl_pend = reg_wr && reg_addr == `ASIR_ADDR_CTRL_PEND;
  assign wr_range_pend = reg_wr && reg_addr == `ASIR_ADDR_RANGE_PEND;
  assign wr_gpio = reg_wr && reg_addr == `ASIR_ADDR_GPIO_DATA;
  // pointer step and its place in the channel block
  assign step_addr = reg_addr + 8'h1;
  assign chan_off = step_addr - `ASIR_ADDR_CH_BASE;
  assign skip_zone = (step_addr >= `ASIR_ADDR_CH_BASE) &&
                     (step_addr < `ASIR_ADDR_CH_BASE + 8'h4);
  assign rate_code = active_control_image_q[`ASIR_MODE_MSB:`ASIR_MODE_LSB];
  // set mask bit means channel leaves the conversion cycle
  assign chan_active = ~active_control_image_q[`ASIR_MASK_MSB:`ASIR_MASK_LSB];
  assign range_active = range_act_q;
  assign images_valid = valid_q;
  assign ctrl_commit = {ctrl_pend_q[15:4], 4'h0};
  // mode decode of the active code; the adaptive, continuous and
  // reserved flags have no user in this block
  asir_mode_dec u_dec (
    .mode_code(rate_code),
    .slow_force(slow_force),
    .adaptive(),
    .continuous(),
    .single_shot(single_shot),
    .fast(fast),
    .burst(burst),
    .sleep(sleep),
    .reserved(),
    .rate_sel(rate_sel)
  );
  // pending writes, commit on cycle end, whole-word image load
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_pend_q <= CTRL_RESET;
      range_pend_q <= `ASIR_RANGE_RESET;
      active_control_image_q <= CTRL_RESET;
      range_act_q <= `ASIR_RANGE_RESET;
      gpio_out_q <= 2'h0;
      commit_q <= 1'b0;
    end else begin
      // host writes go to pending words and gp output values only
      if (wr_ctrl_pend) begin
        ctrl_pend_q <= reg_wdata; // held, not active
      end else if (wr_range_pend) begin
        range_pend_q <= reg_wdata; // held, not active
      end else if (wr_gpio) begin
        // kept in every role, drives the pin only in output role
        gpio_out_q <= reg_wdata[1:0];
      end
      // old rate stays until current cycle finishes; a refresh
      // in the same cycle as the end still commits next end
      if (commit_q && cycle_done) begin
        active_control_image_q <= ctrl_commit;
        range_act_q <= range_pend_q;
      end
      if (refresh) begin
        commit_q <= 1'b1; // set wins over clear
      end else if (cycle_done) begin
        commit_q <= 1'b0;
      end
    end
  end
  // validity timer, restarted by every refresh variant
  always @(posedge core_clk) begin
    if (rst) begin
      valid_cnt_q <= 32'h0;
      valid_q <= 1'b0;
    end else if (refresh) begin
      valid_cnt_q <= 32'h0;
      valid_q <= 1'b0;
    end else if (!valid_q) begin
      valid_cnt_q <= valid_cnt_q + 32'h1;
      if (valid_cnt_q >= VALID_CYC - 1) begin
        valid_q <= 1'b1;
      end
    end
  end
  // read data; unmapped addresses return zero
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0;
    end else if (reg_rd) begin
      if (reg_addr == `ASIR_ADDR_ACTIVE_CONTROL_IMAGE) begin
        reg_rdata <= {active_control_image_q[15:4], 4'h0};
      end else if (reg_addr == `ASIR_ADDR_RANGE_ACT) begin
        reg_rdata <= range_act_q;
      end else if (reg_addr == `ASIR_ADDR_CTRL_PEND) begin
        reg_rdata <= ctrl_pend_q;
      end else if (reg_addr == `ASIR_ADDR_RANGE_PEND) begin
        reg_rdata <= range_pend_q;
      end else if (reg_addr == `ASIR_ADDR_GPIO_DATA) begin
        // input role shows pin, output role shows written value
        reg_rdata <= {14'h0, pin_rd};
      end else begin
        reg_rdata <= 16'h0;
      end
    end
  end
  // auto-increment pointer, skipping per-channel addresses
  always @(posedge core_clk) begin
    if (rst) begin
      next_addr <= 8'h0;
    end else if (reg_rd || reg_wr) begin
      if (reg_auto_inc && !skip_override && skip_zone &&
          !chan_active[chan_off[1:0]]) begin
        // disabled channel: step over its address
        next_addr <= reg_addr + 8'h2;
      end else begin
        // plain step, also when the override is high
        next_addr <= step_addr;
      end
    end
  end
endmodule // asir_regs

// file: design/asir_defines.vh
// Purpose: constants for the active settings image registers
// Assumes: 16-bit registers, byte-wide register index
// Notes: included by the asir regs and mode decode files
`ifndef ASIR_DEFINES_VH
`define ASIR_DEFINES_VH
`define ASIR_ADDR_CTRL_PEND 8'h01
`define ASIR_ADDR_GPIO_DATA 8'h0e
`define ASIR_ADDR_RANGE_PEND 8'h1d
`define ASIR_ADDR_ACTIVE_CONTROL_IMAGE 8'h21
`define ASIR_ADDR_RANGE_ACT 8'h22
`define ASIR_ADDR_CH_BASE 8'h0b
`define ASIR_CTRL_RESET 16'h0700
`define ASIR_RANGE_RESET 16'h0000
`define ASIR_MODE_MSB 15
`define ASIR_MODE_LSB 12
`define ASIR_PIN2_MSB 11
`define ASIR_PIN2_LSB 10
`define ASIR_PIN1_MSB 9
`define ASIR_PIN1_LSB 8
`define ASIR_MASK_MSB 7
`define ASIR_MASK_LSB 4
`define ASIR_PIN_ALERT 2'h0
`define ASIR_PIN_GPIN 2'h1
`define ASIR_PIN_GPOUT 2'h2
`define ASIR_PIN_SLOW 2'h3
`define ASIR_MODE_SS 4'h8
`define ASIR_MODE_SS8 4'h9
`define ASIR_MODE_FAST 4'ha
`define ASIR_MODE_BURST 4'hb
`define ASIR_MODE_SLEEP 4'hf
`define ASIR_MODE_SLOW8 4'h7
`define ASIR_RATE_SLOW8 2'h3
`define ASIR_VALID_NS 1000000
`define ASIR_CLK_NS 4
`endif

// file: design/asir_sync2.v
// Purpose: two-flop synchroniser for pin levels
// Assumes: core_clk domain
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module asir_sync2 #(
  parameter W = 2
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // data
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q; // first stage, read only by second
  reg [W-1:0] sync_q; // second stage
  // plain double flop
  always @(posedge core_clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // asir_sync2

// file: design/asir_mode_dec.v
// Purpose: decode of the sampling mode code
// Assumes: 4-bit code from the active control image
// Notes: one-hot output, reserved codes raise only the reserved flag
`timescale 1ns/1ps
`include "asir_defines.vh"
module asir_mode_dec (
  // code in
  input wire [3:0] mode_code,
  input wire slow_force,
  // decoded mode
  output reg adaptive,
  output reg continuous,
  output reg single_shot,
  output reg fast,
  output reg burst,
  output reg sleep,
  output reg reserved,
  output reg [1:0] rate_sel
);
  // one mode per code; slow pin forces lowest rate in adaptive and continuous modes
  always @* begin
    adaptive = 1'b0;
    continuous = 1'b0;
    single_shot = 1'b0;
    fast = 1'b0;
    burst = 1'b0;
    sleep = 1'b0;
    reserved = 1'b0;
    rate_sel = mode_code[1:0];
    if (mode_code[3:2] == 2'h0) begin
      adaptive = 1'b1;
    end else if (mode_code[3:2] == 2'h1) begin
      continuous = 1'b1;
    end else if (mode_code == `ASIR_MODE_SS ||
                 mode_code == `ASIR_MODE_SS8) begin
      single_shot = 1'b1;
    end else if (mode_code == `ASIR_MODE_FAST) begin
      fast = 1'b1;
    end else if (mode_code == `ASIR_MODE_BURST) begin
      burst = 1'b1;
    end else if (mode_code == `ASIR_MODE_SLEEP) begin
      sleep = 1'b1;
    end else begin
      reserved = 1'b1;
    end
    // low-rate pin drops rate to 8 per second
    if (slow_force && (adaptive || continuous)) begin
      rate_sel = `ASIR_RATE_SLOW8;
    end
  end
endmodule // asir_mode_dec

// file: dv/asir_regs_chk.sv
// Purpose: port checker for the active image registers
// Assumes: one clock, rst synchronous active high
// Notes: bound to asir_regs below the module
`timescale 1ns/1ps
module asir_regs_chk (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_rdata,
  // events
  input wire cycle_done,
  input wire refresh,
  // active state
  input wire [3:0] chan_active,
  input wire [3:0] rate_code,
  input wire sleep,
  input wire single_shot,
  input wire fast,
  input wire burst,
  input wire [15:0] range_active,
  input wire images_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // read of the control image, no commit in the same cycle
  sequence s_ctl_rd;
    reg_rd && reg_addr == 8'h21 && !cycle_done;
  endsequence
  property p_nib;
    s_ctl_rd |=> reg_rdata[3:0] == 4'h0;
  endproperty
  a_nib: assert property (p_nib) else $error("low nibble set");
  property p_rdm;
    s_ctl_rd |=> reg_rdata[7:4] == ~$past(chan_active)
      && reg_rdata[15:12] == $past(rate_code);
  endproperty
  a_rdm: assert property (p_rdm) else $error("image vs state");
  // images only move at a conversion cycle end
  property p_hold;
    !cycle_done |=> $stable(rate_code) && $stable(range_active);
  endproperty
  a_hold: assert property (p_hold) else $error("image moved");
  property p_dec6;
    fast == (rate_code == 4'ha) && burst == (rate_code == 4'hb)
      && single_shot == (rate_code[3:1] == 3'h4);
  endproperty
  a_dec6: assert property (p_dec6) else $error("mode decode");
  property p_sleep;
    sleep == (rate_code == 4'hf);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep decode");
  property p_one;
    $onehot0({sleep, single_shot, fast, burst});
  endproperty
  a_one: assert property (p_one) else $error("two modes");
  // valid flag drops on refresh and returns within the window
  property p_vlo;
    refresh |=> !images_valid [*8];
  endproperty
  a_vlo: assert property (p_vlo) else $error("valid too early");
  property p_vwin;
    refresh |-> ##[1:40] images_valid;
  endproperty
  a_vwin: assert property (p_vwin) else $error("valid late");
  property p_unmap;
    reg_rd && reg_addr == 8'h50 |=> reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
endmodule // asir_regs_chk
bind asir_regs asir_regs_chk u_chk (.core_clk(core_clk), .rst(rst),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .cycle_done(cycle_done), .refresh(refresh), .chan_active(chan_active),
  .rate_code(rate_code), .sleep(sleep), .single_shot(single_shot),
  .fast(fast), .burst(burst), .range_active(range_active),
  .images_valid(images_valid));

// file: dv/asir_host.sv
// Purpose: host controller model on the register port
// Assumes: requests launched on the falling edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module asir_host (
  // clock
  input wire core_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  // commands
  output logic refresh
);
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    refresh = 1'h0;
  end
  // one access; strobe held over exactly one rising edge
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge core_clk);
    q = reg_rdata;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // refresh command pulse
  task pulse;
    @(negedge core_clk);
    refresh = 1'h1;
    @(negedge core_clk);
    refresh = 1'h0;
  endtask
endmodule // asir_host

// file: dv/active_settings_image_regs_tb_top.sv
// Purpose: directed test of the active image registers
// Assumes: VALID_CYC shortened to 20 cycles
// Notes: commit waits 25 cycles so images are valid
`timescale 1ns/1ps
module active_settings_image_regs_tb_top;
  logic core_clk, rst, cycle_done, pin1_in, pin2_in;
  logic auto_inc, skip_ovr;
  wire reg_wr, reg_rd, refresh, pin1_out, pin1_oe_n, pin2_out, pin2_oe_n;
  wire sleep, single_shot, fast, burst, images_valid;
  wire [7:0] reg_addr, next_addr;
  wire [15:0] reg_wdata, reg_rdata, range_active;
  wire [3:0] chan_active, rate_code;
  wire [1:0] rate_sel;
  int n_errors, checks;
  logic [15:0] rv;
  asir_regs #(.VALID_CYC(20)) DUT (.core_clk(core_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_auto_inc(auto_inc),
    .skip_override(skip_ovr),
    .reg_rdata(reg_rdata), .next_addr(next_addr), .refresh(refresh),
    .cycle_done(cycle_done), .pin1_in(pin1_in), .pin2_in(pin2_in),
    .pin1_out(pin1_out), .pin1_oe_n(pin1_oe_n), .pin2_out(pin2_out),
    .pin2_oe_n(pin2_oe_n), .chan_active(chan_active),
    .rate_code(rate_code), .rate_sel(rate_sel), .sleep(sleep),
    .single_shot(single_shot), .fast(fast), .burst(burst),
    .range_active(range_active), .images_valid(images_valid));
  asir_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .refresh(refresh));
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare a port value
  task chkp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t %s got %h", $time, m, got);
    end
  endtask
  // read a register and compare the word
  task chkr(input logic [7:0] a, input logic [15:0] exp);
    host.acc(1'h0, a, 16'h0000, rv);
    chkp(rv, exp, "register read");
  endtask
  // write pending, refresh, then end the conversion cycle late
  task commit(input logic [7:0] a, input logic [15:0] d);
    host.acc(1'h1, a, d, rv);
    host.pulse();
    repeat (25) @(negedge core_clk);
    cycle_done = 1'h1;
    @(negedge core_clk);
    cycle_done = 1'h0;
  endtask
  // watchdog well beyond the directed run
  initial begin
    #40000;
    n_errors++;
    finish_test();
  end
  initial begin
    n_errors = 0;
    checks = 0;
    rst = 1'h1;
    cycle_done = 1'h0;
    pin1_in = 1'h0;
    pin2_in = 1'h0;
    auto_inc = 1'h0;
    skip_ovr = 1'h0;
    repeat (6) @(negedge core_clk);
    rst = 1'h0;
    chkr(8'h21, 16'h0700);
    chkr(8'h22, 16'h0000);
    chkr(8'h50, 16'h0000);
    // pending stays hidden across refresh until the cycle ends
    host.acc(1'h1, 8'h01, 16'ha65f, rv);
    host.pulse();
    chkp({15'h0, images_valid}, 16'h0000, "valid dropped");
    chkr(8'h21, 16'h0700);
    repeat (25) @(negedge core_clk);
    cycle_done = 1'h1;
    @(negedge core_clk);
    cycle_done = 1'h0;
    chkr(8'h21, 16'ha650);
    host.acc(1'h1, 8'h21, 16'hffff, rv);
    chkr(8'h21, 16'ha650);
    chkp(chan_active, 16'h000a, "channel mask");
    chkp(fast, 16'h0001, "fast mode");
    chkp(pin2_oe_n, 16'h0001, "pin2 input");
    chkp(pin1_oe_n, 16'h0000, "pin1 drives");
    chkp(images_valid, 16'h0001, "valid");
    // mask 0x5 disables the first and third channels
    auto_inc = 1'h1;
    chkr(8'h0c, 16'h0000);
    chkp(next_addr, 16'h000e, "pointer skip");
    skip_ovr = 1'h1;
    chkr(8'h0c, 16'h0000);
    chkp(next_addr, 16'h000d, "pointer no skip");
    auto_inc = 1'h0;
    skip_ovr = 1'h0;
    // pin one drives the written bit, pin two is read back
    host.acc(1'h1, 8'h0e, 16'h0001, rv);
    chkp({15'h0, pin1_out}, 16'h0001, "pin1 level");
    pin2_in = 1'h1;
    repeat (3) @(negedge core_clk);
    chkr(8'h0e, 16'h0003);
    pin2_in = 1'h0;
    // every sampling code
    for (int i = 0; i < 16; i++) begin
      commit(8'h01, {i[3:0], 12'h700});
      chkr(8'h21, {i[3:0], 12'h700});
      chkp(sleep, i == 15, "sleep");
      chkp(single_shot, i == 8 || i == 9, "single shot");
      chkp(burst, i == 11, "burst");
      chkp(fast, i == 10, "fast");
      if (i < 8)
        chkp(rate_sel, i[1:0], "rate");
    end
    // low-rate pin forces the slowest rate
    commit(8'h01, 16'h0700);
    pin1_in = 1'h1;
    repeat (4) @(negedge core_clk);
    chkp(rate_sel, 16'h0003, "slow forced");
    pin1_in = 1'h0;
    repeat (4) @(negedge core_clk);
    chkp(rate_sel, 16'h0000, "slow released");
    // range image
    host.acc(1'h1, 8'h1d, 16'h6e19, rv);
    chkr(8'h22, 16'h0000);
    commit(8'h22, 16'hffff);
    chkr(8'h22, 16'h6e19);
    chkp(range_active, 16'h6e19, "range port");
    // reset in mid-run brings back the defaults
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    chkp({15'h0, images_valid}, 16'h0000, "valid reset");
    chkr(8'h21, 16'h0700);
    chkr(8'h22, 16'h0000);
    finish_test();
  end
endmodule // active_settings_image_regs_tb_top
